// ==== common/sacc_consts.svh ====
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH
`define SACC_ADDR_CTRL 8'h1F
`define SACC_ADDR_PINCFG 8'h9F
`define SACC_ADDR_RESULT 8'h1E
`define SACC_ADDR_FLAG 8'h0C
`define SACC_ADDR_ENABLE 8'h8C
`define SACC_ADDR_INTCTL 8'h0B
`define SACC_ADDR_PORTA 8'h05
`define SACC_ADDR_PORTE 8'h09
`define SACC_CTRL_RESET 8'h00
`define SACC_PINCFG_RESET 3'h0
`define SACC_BIT_POWER 0
`define SACC_BIT_GO 2
`define SACC_BIT_DONE 6
`define SACC_BIT_CONV_IE 6
`define SACC_BIT_PERIPH_IE 6
`define SACC_BIT_GLOBAL_IE 7
`define SACC_TRIG_MODE 4'hB
`define SACC_DIV2_HALF 5'h00
`define SACC_DIV8_HALF 5'h03
`define SACC_DIV32_HALF 5'h0F
`define SACC_BIT_PERIODS 4'h9
`define SACC_RC_DELAY 2'h3
`endif

// ==== common/sacc_pkg.sv ====
package sacc_pkg;
	typedef enum logic [1:0] {
		SACC_CLK_DIV2 = 2'h0,
		SACC_CLK_DIV8 = 2'h1,
		SACC_CLK_DIV32 = 2'h2,
		SACC_CLK_RC = 2'h3
	} sacc_clk_sel_t;
	typedef enum logic [3:0] {
		SACC_IDLE = 4'h1,
		SACC_WAIT = 4'h2,
		SACC_CONV = 4'h4,
		SACC_DONE = 4'h8
	} sacc_state_t;
endpackage

// ==== sim/sacc_sar_model.sv ====
`timescale 1ns/1ps
// Sample-and-hold and comparator stand-in: one level per input channel
module sacc_sar_model (
	input wire logic ref_clk_i,
	input wire logic analog_on_i,
	input wire logic sample_i,
	input wire logic [2:0] mux_sel_i,
	input wire logic [7:0] sar_trial_i,
	input wire logic [63:0] levels_i,
	output logic conv_bit_o
);
	logic [7:0] held_ff = 8'h00;
	logic junk_ff = 1'h0;

	// Track the selected pin while sampling, then freeze it for the bit trials
	always @(posedge ref_clk_i) begin
		if (analog_on_i && sample_i) begin
			held_ff <= levels_i[{mux_sel_i, 3'h0} +: 8];
		end
		junk_ff <= ~junk_ff;
	end

	// Unpowered comparator gives no usable answer, so it toggles
	assign conv_bit_o = analog_on_i ? (held_ff >= sar_trial_i) : junk_ff;
endmodule

// ==== sim/sar_adc_control_tb.sv ====
`timescale 1ns/1ps
// Register bus stimulus with a queue of expected read data
module sar_adc_control_tb;
	typedef struct {logic [7:0] e; logic [7:0] m;} sacc_exp_t;
	logic ref_clk_i = 1'h0, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, rc_clk_i = 1'h0;
	logic sleep_i = 1'h0, cmp_trig_i = 1'h0, rd_seen = 1'h0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, pin_level_i = 8'h00, gcnt = 8'h00;
	logic [7:0] rdata_o, sar_trial_o, analog_pins_o, last, v, m, gap;
	logic [3:0] cmp_mode_i = 4'h0;
	logic [2:0] mux_sel_o;
	logic conv_bit_i, analog_on_o, sample_o, sar_step_o, vref_ext_o, wake_o, irq_o;
	logic [63:0] levels = 64'h0;
	logic [7:0] ax [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
	logic [7:0] gx [4] = '{8'h02, 8'h08, 8'h20, 8'h0E};
	logic [7:0] vx = 8'h2A;
	int n_mismatch = 0, checks = 0, steps = 0, rcc = 0;
	sacc_exp_t q[$];
	sacc_exp_t ex;

	sacc_top u_dut (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rc_clk_i,
		.sleep_i, .cmp_mode_i, .cmp_trig_i, .pin_level_i, .conv_bits_i(8'h00), .conv_bit_i,
		.mux_sel_o, .analog_on_o, .sample_o, .sar_step_o, .sar_trial_o, .analog_pins_o,
		.vref_ext_o, .wake_o, .irq_o);
	sacc_sar_model u_sar (.ref_clk_i, .analog_on_i(analog_on_o), .sample_i(sample_o),
		.mux_sel_i(mux_sel_o), .sar_trial_i(sar_trial_o), .levels_i(levels),
		.conv_bit_o(conv_bit_i));

	always #2 ref_clk_i = ~ref_clk_i;

	// RC source runs free at 14 cycles; steps counted with the last gap
	always @(posedge ref_clk_i) begin
		rcc <= (rcc == 6) ? 0 : rcc + 1;
		if (rcc == 6) rc_clk_i <= ~rc_clk_i;
		gcnt <= sar_step_o ? 8'h01 : gcnt + 8'h01;
		if (sar_step_o) begin
			gap <= gcnt;
			steps <= steps + 1;
		end
		rd_seen <= rd_i;
	end

	// Read data is only valid in the cycle after the strobe
	always @(negedge ref_clk_i) begin
		if (rd_seen === 1'h1) begin
			ex = q.pop_front();
			chk("rdata", ex.e & ex.m, rdata_o & ex.m);
		end
	end

	task automatic chk(input string s, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic fail;
		n_mismatch++;
		print_verdict();
	endtask

	// One strobe cycle; a gap edge follows so strobes never retoggle in one step
	task automatic bus(input logic w, input logic [7:0] a, d, mk);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
		if (!w) q.push_back('{d, mk});
		@(posedge ref_clk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, d);
		bus(1'h1, a, d, 8'h00);
	endtask

	task automatic rd(input logic [7:0] a, e, mk);
		bus(1'h0, a, e, mk);
	endtask

	// Poll go/busy with a bound; polling reads carry no expectation
	task automatic idle;
		for (int k = 0; k < 600; k++) begin
			rd(8'h1F, 8'h00, 8'h00);
			@(negedge ref_clk_i);
			if (rdata_o[2] === 1'h0) return;
		end
		fail();
	endtask

	task automatic nstep(input int n);
		n += steps;
		for (int k = 0; k < 900 && steps < n; k++) @(posedge ref_clk_i);
		if (steps < n) fail();
	endtask

	task automatic conv(input logic [1:0] s, input logic [2:0] c);
		int n;
		last = 8'($urandom);
		levels[{c, 3'h0} +: 8] = last;
		wr(8'h1F, {s, c, 3'h1});
		repeat (4) @(posedge ref_clk_i);
		n = steps;
		wr(8'h1F, {s, c, 3'h5});
		rd(8'h1F, 8'h04, 8'h04);
		idle();
		chk("steps", 8'h09, 8'(steps - n));
		chk("gap", gx[s], gap);
		chk("chan", c, mux_sel_o);
		rd(8'h1E, last, 8'hFF);
		rd(8'h0C, 8'h40, 8'h40);
	endtask

	initial begin
		void'($urandom(32'h25B93361));
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		// Reset state and an unmapped address
		rd(8'h1F, 8'h00, 8'hFF);
		rd(8'h9F, 8'h00, 8'hFF);
		rd(8'h40, 8'h00, 8'hFF);
		chk("apins", 8'hFF, analog_pins_o);
		// Every port configuration code; analog pins must read low
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			pin_level_i <= v;
			wr(8'h9F, 8'(i));
			repeat (4) @(negedge ref_clk_i);
			m = vx[i] ? 8'hF7 : 8'hFF;
			rd(8'h9F, 8'(i), 8'hFF);
			chk("apins", ax[i] & m, analog_pins_o & m);
			chk("vref", vx[i], vref_ext_o);
			rd(8'h05, {2'h0, v[4] & ~ax[i][4], 1'h0, v[3:0] & ~ax[i][3:0]}, m & 8'hEF);
			rd(8'h09, {5'h00, v[7:5] & ~ax[i][7:5]}, 8'hFF);
		end
		wr(8'h9F, 8'h00);
		// Every channel, every clock select
		for (int i = 0; i < 8; i++) begin
			conv(2'(i), 3'(i));
			wr(8'h0C, 8'h00);
		end
		// Start in the power-on write, or in a write that clears power, is refused
		wr(8'h1F, 8'h00);
		wr(8'h1F, 8'h05);
		rd(8'h1F, 8'h01, 8'hFF);
		wr(8'h1F, 8'h04);
		rd(8'h1F, 8'h00, 8'hFF);
		chk("aon", 8'h00, analog_on_o);
		// Abort by power clear, go clear and sleep on a divided clock
		for (int i = 0; i < 3; i++) begin
			wr(8'h1F, 8'h01);
			levels[7:0] = ~last;
			wr(8'h1F, 8'h05);
			nstep(3);
			if (i == 2) sleep_i <= 1'h1;
			else wr(8'h1F, 8'(i));
			repeat (4) @(negedge ref_clk_i);
			rd(8'h1F, (i == 0) ? 8'h00 : 8'h01, 8'hFF);
			rd(8'h1E, last, 8'hFF);
			rd(8'h0C, 8'h00, 8'h40);
			chk("aon", i == 1, analog_on_o);
			sleep_i <= 1'h0;
		end
		conv(2'h0, 3'h0);
		wr(8'h0C, 8'h00);
		// Compare trigger: wrong mode, right mode, converter off
		for (int i = 0; i < 3; i++) begin
			wr(8'h1F, (i == 2) ? 8'h00 : 8'h01);
			cmp_mode_i <= (i == 0) ? 4'h5 : 4'hB;
			cmp_trig_i <= 1'h1;
			repeat (4) @(posedge ref_clk_i);
			cmp_trig_i <= 1'h0;
			repeat (2) @(posedge ref_clk_i);
			rd(8'h1F, (i == 1) ? 8'h05 : {7'h00, i == 0}, 8'hFF);
			idle();
			rd(8'h0C, (i == 1) ? 8'h40 : 8'h00, 8'h40);
			wr(8'h0C, 8'h00);
		end
		// Done flag qualified by the enables
		wr(8'h0B, 8'hC0);
		conv(2'h0, 3'h4);
		chk("wake", 8'h00, wake_o);
		chk("irq", 8'h00, irq_o);
		wr(8'h8C, 8'h40);
		wr(8'h0B, 8'h40);
		repeat (2) @(negedge ref_clk_i);
		chk("wake", 8'h01, wake_o);
		chk("irq", 8'h00, irq_o);
		wr(8'h0B, 8'hC0);
		repeat (2) @(negedge ref_clk_i);
		chk("irq", 8'h01, irq_o);
		wr(8'h0C, 8'h00);
		repeat (2) @(negedge ref_clk_i);
		chk("wake", 8'h00, wake_o);
		// Reset in mid-conversion
		wr(8'h9F, 8'h06);
		wr(8'h1F, 8'h05);
		repeat (8) @(posedge ref_clk_i);
		rstn_i <= 1'h0;
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		rd(8'h1F, 8'h00, 8'hFF);
		rd(8'h9F, 8'h00, 8'hFF);
		chk("apins", 8'hFF, analog_pins_o);
		chk("aon", 8'h00, analog_on_o);
		print_verdict();
	end
endmodule

// ==== verilog/sacc_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for pin-side levels
module sacc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] q_ff;
	initial begin
		if (WIDTH < 1) $error("width must be positive");
	end
	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d_i;
			q_ff <= meta_ff;
		end
	end
	assign q_o = q_ff;
endmodule

// ==== verilog/sacc_tick.sv ====
`timescale 1ns/1ps
`include "sacc_consts.svh"
// Conversion clock tick generator: one pulse per per-bit period
module sacc_tick (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic [1:0] sel_i,
	input wire logic rc_edge_i,
	output logic tick_o
);
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic half_ff;
	logic nxt_half;
	logic [4:0] limit;
	logic fire;
	// Limit is half period minus one; a full period is two halves
	always_comb begin
		limit = `SACC_DIV2_HALF;
		fire = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_half = half_ff;
		unique case (sacc_pkg::sacc_clk_sel_t'(sel_i))
			sacc_pkg::SACC_CLK_DIV2: limit = `SACC_DIV2_HALF;
			sacc_pkg::SACC_CLK_DIV8: limit = `SACC_DIV8_HALF;
			sacc_pkg::SACC_CLK_DIV32: limit = `SACC_DIV32_HALF;
			sacc_pkg::SACC_CLK_RC: limit = 5'h00;
		endcase
		if (!run_i) begin
			nxt_cnt = 5'h00;
			nxt_half = 1'b0;
		end else if (sel_i == 2'h3) begin
			fire = rc_edge_i;
		end else if (cnt_ff == limit) begin
			nxt_cnt = 5'h00;
			nxt_half = ~half_ff;
			fire = half_ff;
		end else begin
			nxt_cnt = cnt_ff + 5'h01;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			cnt_ff <= 5'h00;
			half_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			half_ff <= nxt_half;
		end
	end
	assign tick_o = fire;
endmodule

// ==== verilog/sacc_top.sv ====
`timescale 1ns/1ps
`include "sacc_consts.svh"
// Converter control: registers, sequencer, pin configuration
module sacc_top (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic rc_clk_i,
	input wire logic sleep_i,
	input wire logic [3:0] cmp_mode_i,
	input wire logic cmp_trig_i,
	input wire logic [7:0] pin_level_i,
	input wire logic [7:0] conv_bits_i,
	input wire logic conv_bit_i,
	output logic [2:0] mux_sel_o,
	output logic analog_on_o,
	output logic sample_o,
	output logic sar_step_o,
	output logic [7:0] sar_trial_o,
	output logic [7:0] analog_pins_o,
	output logic vref_ext_o,
	output logic wake_o,
	output logic irq_o
);
	// Pin order in analog_pins_o / pin_level_i: RA0 RA1 RA2 RA3 RA5 RE0 RE1 RE2
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [2:0] pcfg_ff;
	logic [2:0] nxt_pcfg;
	logic [7:0] result_ff;
	logic [7:0] nxt_result;
	logic [7:0] flag_ff;
	logic [7:0] nxt_flag;
	logic [7:0] pie_ff;
	logic [7:0] nxt_pie;
	logic [7:0] interrupt_control_reg_ff;
	logic [7:0] nxt_interrupt_control_reg;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	sacc_pkg::sacc_state_t state_ff;
	sacc_pkg::sacc_state_t nxt_state;
	logic [3:0] bitcnt_ff;
	logic [3:0] nxt_bitcnt;
	logic [1:0] delay_ff;
	logic [1:0] nxt_delay;
	logic [7:0] sar_ff;
	logic [7:0] nxt_sar;
	logic [2:0] conv_idx_ff;
	logic [2:0] nxt_conv_idx;
	logic [7:0] pins_s;
	logic rc_s;
	logic sleep_s;
	logic trig_s;
	logic cmp_bit_s;
	logic rc_prev_ff;
	logic trig_prev_ff;
	logic rc_edge;
	logic trig_edge;
	logic tick;
	logic busy;
	logic power;
	logic halted;
	logic wr_ctrl;
	logic start_req;
	logic abort_req;
	logic finish;
	logic [7:0] analog_map;
	logic [7:0] trial_bit;

	// External levels cross into the clock domain before use
	sacc_sync #(.WIDTH(8)) u_pin_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.d_i(pin_level_i),
		.q_o(pins_s)
	);
	sacc_sync #(.WIDTH(3)) u_ctl_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.d_i({rc_clk_i, sleep_i, cmp_trig_i}),
		.q_o({rc_s, sleep_s, trig_s})
	);
	// Comparator answers our own trial on this clock; two sync stages would
	// not fit inside the two-cycle period of the fastest clock select
	assign cmp_bit_s = conv_bit_i;

	// Edge detectors read only synchronised signals
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rc_prev_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else begin
			rc_prev_ff <= rc_s;
			trig_prev_ff <= trig_s;
		end
	end
	assign rc_edge = rc_s & ~rc_prev_ff;
	assign trig_edge = trig_s & ~trig_prev_ff;

	assign power = ctrl_ff[`SACC_BIT_POWER];
	assign busy = ctrl_ff[`SACC_BIT_GO];
	// RC clock keeps running in sleep; other sources stop the converter
	assign halted = sleep_s && (ctrl_ff[7:6] != 2'h3);

	sacc_tick u_tick (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.run_i(state_ff == sacc_pkg::SACC_CONV),
		.sel_i(ctrl_ff[7:6]),
		.rc_edge_i(rc_edge),
		.tick_o(tick)
	);

	// Pin configuration decode, bit order as the pin list above
	always_comb begin
		unique case (pcfg_ff)
			3'h0, 3'h1: analog_map = 8'hFF;
			3'h2, 3'h3: analog_map = 8'h1F;
			3'h4, 3'h5: analog_map = 8'h0B;
			default: analog_map = 8'h00;
		endcase
		// RA3 becomes reference input in odd codes below 110
		if (pcfg_ff[0] && !pcfg_ff[2]) begin
			analog_map[3] = 1'b0;
		end else if (pcfg_ff == 3'h5) begin
			analog_map[3] = 1'b0;
		end
	end
	assign vref_ext_o = pcfg_ff[0] && (pcfg_ff[2:1] != 2'h3);
	assign analog_pins_o = analog_map;

	assign wr_ctrl = wr_i && (addr_i == `SACC_ADDR_CTRL);
	// Start needs power on before this write and kept on by it; a write that
	// drops power also masks a trigger in the same cycle
	assign start_req = power && !busy && !(wr_ctrl && !wdata_i[`SACC_BIT_POWER]) &&
		((wr_ctrl && wdata_i[`SACC_BIT_GO]) ||
		(trig_edge && cmp_mode_i == `SACC_TRIG_MODE));
	assign abort_req = busy && ((wr_ctrl && (!wdata_i[`SACC_BIT_GO] ||
		!wdata_i[`SACC_BIT_POWER])) || halted);
	assign finish = (state_ff == sacc_pkg::SACC_CONV) && tick &&
		(bitcnt_ff == `SACC_BIT_PERIODS - 4'h1);
	// Bit under trial: count 1 tries bit 7, count 8 tries bit 0
	assign trial_bit = 8'h80 >> (bitcnt_ff[2:0] - 3'h1);

	// Sequencer: optional RC wait, nine periods, then completion
	always_comb begin
		nxt_state = state_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_delay = delay_ff;
		nxt_sar = sar_ff;
		nxt_conv_idx = conv_idx_ff;
		unique case (state_ff)
			sacc_pkg::SACC_IDLE, sacc_pkg::SACC_DONE: begin
				// A start right after completion must not be lost
				nxt_state = sacc_pkg::SACC_IDLE;
				if (start_req) begin
					nxt_conv_idx = ctrl_ff[5:3];
					nxt_sar = 8'h80;
					nxt_bitcnt = 4'h0;
					nxt_delay = `SACC_RC_DELAY;
					nxt_state = (ctrl_ff[7:6] == 2'h3) ? sacc_pkg::SACC_WAIT :
						sacc_pkg::SACC_CONV;
				end
			end
			sacc_pkg::SACC_WAIT: begin
				if (abort_req) begin
					nxt_state = sacc_pkg::SACC_IDLE;
				end else if (delay_ff == 2'h0) begin
					nxt_state = sacc_pkg::SACC_CONV;
				end else begin
					nxt_delay = delay_ff - 2'h1;
				end
			end
			sacc_pkg::SACC_CONV: begin
				if (abort_req) begin
					nxt_state = sacc_pkg::SACC_IDLE;
				end else if (tick) begin
					nxt_bitcnt = bitcnt_ff + 4'h1;
					// First period samples; the next eight resolve bits MSB first
					if (bitcnt_ff != 4'h0) begin
						nxt_sar = (cmp_bit_s ? sar_ff : (sar_ff & ~trial_bit)) |
							(trial_bit >> 1);
					end
					if (finish) begin
						nxt_state = sacc_pkg::SACC_DONE;
					end
				end
			end
			default: nxt_state = sacc_pkg::SACC_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_ff <= sacc_pkg::SACC_IDLE;
			bitcnt_ff <= 4'h0;
			delay_ff <= 2'h0;
			sar_ff <= 8'h00;
			conv_idx_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			bitcnt_ff <= nxt_bitcnt;
			delay_ff <= nxt_delay;
			sar_ff <= nxt_sar;
			conv_idx_ff <= nxt_conv_idx;
		end
	end

	// Register writes, hardware updates of go/busy, result and done flag
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_pcfg = pcfg_ff;
		nxt_result = result_ff;
		nxt_flag = flag_ff;
		nxt_pie = pie_ff;
		nxt_interrupt_control_reg = interrupt_control_reg_ff;
		if (wr_i) begin
			unique case (addr_i)
				`SACC_ADDR_CTRL: nxt_ctrl = {wdata_i[7:3], busy, 1'b0, wdata_i[0]};
				`SACC_ADDR_PINCFG: nxt_pcfg = wdata_i[2:0];
				`SACC_ADDR_FLAG: nxt_flag = wdata_i;
				`SACC_ADDR_ENABLE: nxt_pie = wdata_i;
				`SACC_ADDR_INTCTL: nxt_interrupt_control_reg = wdata_i;
				default: ;
			endcase
		end
		if (start_req) begin
			nxt_ctrl[`SACC_BIT_GO] = 1'b1;
		end
		if (abort_req) begin
			nxt_ctrl[`SACC_BIT_GO] = 1'b0;
		end
		if (finish && !abort_req) begin
			nxt_result = {sar_ff[7:1], cmp_bit_s};
			nxt_ctrl[`SACC_BIT_GO] = 1'b0;
			nxt_flag[`SACC_BIT_DONE] = 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			ctrl_ff <= `SACC_CTRL_RESET;
			pcfg_ff <= `SACC_PINCFG_RESET;
			result_ff <= 8'h00;
			flag_ff <= 8'h00;
			pie_ff <= 8'h00;
			interrupt_control_reg_ff <= 8'h00;
		end else begin
			ctrl_ff <= nxt_ctrl;
			pcfg_ff <= nxt_pcfg;
			result_ff <= nxt_result;
			flag_ff <= nxt_flag;
			pie_ff <= nxt_pie;
			interrupt_control_reg_ff <= nxt_interrupt_control_reg;
		end
	end

	// Read mux; analog pins read as zero on the port registers
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				`SACC_ADDR_CTRL: nxt_rdata = ctrl_ff;
				`SACC_ADDR_PINCFG: nxt_rdata = {5'h00, pcfg_ff};
				`SACC_ADDR_RESULT: nxt_rdata = result_ff;
				`SACC_ADDR_FLAG: nxt_rdata = flag_ff;
				`SACC_ADDR_ENABLE: nxt_rdata = pie_ff;
				`SACC_ADDR_INTCTL: nxt_rdata = interrupt_control_reg_ff;
				`SACC_ADDR_PORTA: nxt_rdata = {2'h0, pins_s[4] & ~analog_map[4],
					1'b0, pins_s[3:0] & ~analog_map[3:0]};
				`SACC_ADDR_PORTE: nxt_rdata = {5'h00,
					pins_s[7:5] & ~analog_map[7:5]};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign rdata_o = rdata_ff;

	// Analog side: pin level converted regardless of direction
	assign mux_sel_o = conv_idx_ff;
	assign analog_on_o = power && !halted;
	assign sample_o = (state_ff == sacc_pkg::SACC_CONV) && (bitcnt_ff == 4'h0);
	assign sar_step_o = (state_ff == sacc_pkg::SACC_CONV) && tick;
	assign sar_trial_o = sar_ff;
	// Wake and interrupt qualification from the done flag
	assign wake_o = flag_ff[`SACC_BIT_DONE] && pie_ff[`SACC_BIT_CONV_IE] &&
		interrupt_control_reg_ff[`SACC_BIT_PERIPH_IE];
	assign irq_o = wake_o && interrupt_control_reg_ff[`SACC_BIT_GLOBAL_IE];

	// Checks on control, sequencing and pin decode
	done_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(busy) && !$past(abort_req) |-> flag_ff[`SACC_BIT_DONE])
		else $error("go bit fell without done flag");
	go_start_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_ctrl && wdata_i[2] && wdata_i[0] && power && !busy |=> busy)
		else $error("start not taken");
	abort_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		abort_req |=> $stable(result_ff) && !$rose(flag_ff[6]))
		else $error("abort changed result");
	off_start_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!power && !busy |=> !busy)
		else $error("start while powered off");
	wake_qual_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		flag_ff[6] && pie_ff[6] && interrupt_control_reg_ff[6] |-> wake_o && (irq_o == interrupt_control_reg_ff[7]))
		else $error("wake or interrupt wrong");
	pin_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rd_i && addr_i == 8'h09 && pcfg_ff == 3'h0 |=> rdata_o == 8'h00)
		else $error("analog pin read nonzero");
	rc_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_ff == sacc_pkg::SACC_IDLE && start_req && ctrl_ff[7:6] == 2'h3
		|=> state_ff == sacc_pkg::SACC_WAIT)
		else $error("rc start without wait");
	sleep_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		halted && busy |=> !busy && power)
		else $error("sleep did not abort");
	power_off_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_ctrl && !wdata_i[0] |=> state_ff == sacc_pkg::SACC_IDLE && !busy)
		else $error("power off left conversion running");
	go_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_ctrl && !wdata_i[2] && busy |=> !busy && $stable(result_ff))
		else $error("go clear did not abort");
	chan_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		busy && $past(busy) |-> $stable(mux_sel_o))
		else $error("channel moved during conversion");
	conv_length_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(busy) && !$past(abort_req) |-> $past(bitcnt_ff) == 4'h8)
		else $error("conversion not nine periods");
	pins_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		pcfg_ff == 3'h0 |-> analog_pins_o == 8'hFF && !vref_ext_o)
		else $error("code zero not all analog");
	pins_digital_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		pcfg_ff[2:1] == 2'h3 |-> analog_pins_o == 8'h00 && !vref_ext_o)
		else $error("digital codes left analog pins");
	rc_wait_end_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_ff == sacc_pkg::SACC_WAIT && !abort_req && delay_ff == 2'h0
		|=> state_ff == sacc_pkg::SACC_CONV)
		else $error("rc wait did not end");
endmodule
